/* pkg/asp_if.sv */
/*
  asp_if: register port of the serial device plus its serial pins.
  assumes: the bench loops the serial output pin straight back to the serial input pin.
*/
`timescale 1ns/10ps
interface asp_if;
  logic wr;
  logic rd;
  logic [1:0] addr;
  logic [11:0] wdata;
  logic [11:0] rdata;
  logic irq;
  logic serial_out_pin;
  logic serial_in_pin;
  logic ext_osc;
  logic timer1_ext_input;
  modport dev (input wr, rd, addr, wdata, serial_in_pin, ext_osc,
    timer1_ext_input, output rdata, irq, serial_out_pin);
  modport ctl (output wr, rd, addr, wdata,
    input rdata, irq, serial_out_pin);
endinterface : asp_if

/* pkg/asp_pkg.sv */
/*
  asp_pkg: shared constants for the serial port with timer baud generation.
  assumes: one clock, synchronous active-high reset at both ends.
*/
package asp_pkg;
  // serial_control_reg field positions
  localparam int CTL_MODE = 7;
  localparam int CTL_ONE = 6;
  localparam int CTL_MCE = 5;
  localparam int CTL_REN = 4;
  localparam int CTL_TB8 = 3;
  localparam int CTL_RB8 = 2;
  localparam int CTL_TI = 1;
  localparam int CTL_RI = 0;
  localparam logic [7:0] CTL_RESET = 8'h40;
  // device register indices on its own interface
  localparam logic [1:0] DEV_CTL = 2'h0;
  localparam logic [1:0] DEV_BUF = 2'h1;
  localparam logic [1:0] DEV_TMR = 2'h2;
  // timer settings register fields
  localparam int TMR_RELOAD_LSB = 0;
  localparam int TMR_SRC_LSB = 8;
  localparam int TMR_RUN = 11;
  localparam logic [11:0] TMR_RESET = 12'h000;
  // timer clock sources
  localparam logic [2:0] SRC_SYS = 3'h0;
  localparam logic [2:0] SRC_DIV4 = 3'h1;
  localparam logic [2:0] SRC_DIV12 = 3'h2;
  localparam logic [2:0] SRC_DIV48 = 3'h3;
  localparam logic [2:0] SRC_EXT8 = 3'h4;
  localparam logic [2:0] SRC_PIN = 3'h5;
  localparam int TIMER_SPAN = 256;
  localparam int BITS_8 = 10;
  localparam int BITS_9 = 11;
  // controller AXI4-Lite offsets
  localparam logic [7:0] AX_CTL = 8'h00;
  localparam logic [7:0] AX_BUF = 8'h04;
  localparam logic [7:0] AX_TMR = 8'h08;
  localparam logic [7:0] AX_STAT = 8'h0c;
endpackage : asp_pkg

/* rtl/asp_baud.sv */
/*
  asp_baud: 8-bit auto-reload timer; overflow halved to a bit tick.
  assumes: tick_en is a one-cycle timer clock enable from the source mux.
*/
`timescale 1ns/10ps
module asp_baud (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic tick_en,
  input wire logic [7:0] reload,
  input wire logic force_load,
  output logic bit_tick
);
  logic [7:0] cnt_q;
  logic half_q;
  logic ovf;
  assign ovf = run && tick_en && (cnt_q == 8'hff);
  always_ff @(posedge clk)
  begin
    if (rst || force_load)
      cnt_q <= reload;
    else if (ovf)
      cnt_q <= reload;
    else if (run && tick_en)
      cnt_q <= cnt_q + 8'h01;
  end
  // overflow stream divided by two [R17]
  always_ff @(posedge clk)
  begin
    if (rst)
      half_q <= 1'b0;
    else if (force_load)
      half_q <= 1'b1; // first overflow after forced reload is mid start bit
    else if (ovf)
      half_q <= ~half_q;
  end
  assign bit_tick = ovf && half_q;
endmodule : asp_baud

/* rtl/asp_ctl.sv */
/*
  asp_ctl: AXI4-Lite slave that drives the device register port.
  assumes: one outstanding write and one read; AXI4-Lite master.
*/
`timescale 1ns/10ps
module asp_ctl (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  output logic IRQ,
  asp_if.ctl dev
);
  logic aw_q;
  logic w_q;
  logic [7:0] awa_q;
  logic [11:0] wd_q;
  logic do_wr;
  logic map_wr;
  logic map_rd;
  logic [1:0] rd_idx;
  // a read taken this cycle owns the register port; the write waits
  assign do_wr = aw_q && w_q && !BVALID && !(ARVALID && ARREADY);
  assign map_wr = awa_q == asp_pkg::AX_CTL || awa_q == asp_pkg::AX_BUF
    || awa_q == asp_pkg::AX_TMR;
  assign map_rd = ARADDR == asp_pkg::AX_CTL || ARADDR == asp_pkg::AX_BUF
    || ARADDR == asp_pkg::AX_TMR || ARADDR == asp_pkg::AX_STAT;
  assign rd_idx = ARADDR[3:2];
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 12'h000;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_q <= 1'b1;
        awa_q <= AWADDR;
      end
      if (WVALID && WREADY)
      begin
        w_q <= 1'b1;
        wd_q <= WDATA[11:0];
      end
      if (do_wr)
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
      end
    end
  end
  // ready drops once taken and returns with the response handshake
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
    end
    else
    begin
      if (AWVALID && AWREADY)
        AWREADY <= 1'b0;
      else if (BVALID && BREADY)
        AWREADY <= 1'b1;
      if (WVALID && WREADY)
        WREADY <= 1'b0;
      else if (BVALID && BREADY)
        WREADY <= 1'b1;
    end
  end
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      BVALID <= 1'b0;
      BRESP <= 2'h0;
    end
    else if (do_wr)
    begin
      BVALID <= 1'b1;
      BRESP <= map_wr ? 2'h0 : 2'h2;
    end
    else if (BREADY)
      BVALID <= 1'b0;
  end
  assign dev.wr = do_wr && map_wr;
  assign dev.addr = do_wr ? awa_q[3:2] : rd_idx;
  assign dev.wdata = wd_q;
  assign dev.rd = ARVALID && ARREADY;
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      ARREADY <= 1'b1;
    else if (ARVALID && ARREADY)
      ARREADY <= 1'b0;
    else if (RVALID && RREADY)
      ARREADY <= 1'b1;
  end
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= 2'h0;
    end
    else if (ARVALID && ARREADY)
    begin
      RVALID <= 1'b1;
      RRESP <= map_rd ? 2'h0 : 2'h2;
      if (ARADDR == asp_pkg::AX_STAT)
        RDATA <= {29'h0, dev.serial_out_pin, dev.irq, 1'b0};
      else
        RDATA <= map_rd ? {20'h0, dev.rdata} : 32'h0;
    end
    else if (RREADY)
      RVALID <= 1'b0;
  end
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      IRQ <= 1'b0;
    else
      IRQ <= dev.irq;
  end
endmodule : asp_ctl

/* rtl/asp_dev.sv */
/*
  asp_dev: full-duplex serial port, 8/9-bit framing, timer baud.
  assumes: register port strobes are one-cycle; pins synchronous to clock.
*/
// Implementation choices: register access over AXI4-Lite and the address map.
// Notes on behaviour
// R1: 8-bit frame: start, 8 lsb-first, stop.
// R2: 9-bit frame adds programmable ninth bit.
// R3: control bit 7 picks frame length.
// R4: ninth transmitted bit comes from tx_ninth_bit.
// R5: buffer write starts transmission.
// R6: tx done set at stop-bit start.
// R7: receive only while receive enable set.
// R8: 8-bit: stop to rx ninth, filtered load.
// R9: 9-bit: ninth bit filters, stop ignored.
// R10: failed acceptance leaves latch and flag alone.
// R11: overrun keeps first byte, drops later.
// R12: receive latch frees shifter for next character.
// R13: buffer write to tx, read from latch.
// R14: interrupt when either done flag set.
// R15: software clears done flags itself.
// R16: tx timer visible, rx timer hidden copy.
// R17: overflows halved to form bit rate.
// R18: rx timer shares run and reload.
// R19: start edge reloads rx timer.
// R20: software sets reload for twice baud.
// R21: six selectable timer clock sources.
`timescale 1ns/10ps
module asp_dev (
  input wire logic CLOCK,
  input wire logic RST,
  asp_if.dev bus
);
  logic [7:0] ctl_q;
  logic [11:0] tmr_q;
  logic [7:0] rx_latch_q;
  logic [5:0] pre_q;
  logic [2:0] ext_q;
  logic pin_q;
  logic pin_tick;
  logic sys_en;
  logic tx_tick;
  logic rx_tick;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_cnt_q;
  logic tx_out_q;
  logic [8:0] rx_sh_q;
  logic [3:0] rx_cnt_q;
  logic rx_busy_q;
  logic rx_prev_q;
  logic rx_start;
  logic tx_set;
  logic rx_set;
  logic accept;
  logic irq_q;
  logic [3:0] rx_last;
  // timer clock source select [R21]
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      pre_q <= 6'h00;
    else
      pre_q <= (pre_q == 6'h2f) ? 6'h00 : pre_q + 6'h01;
  end
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      ext_q <= 3'h0;
      pin_q <= 1'b0;
    end
    else
    begin
      ext_q <= bus.ext_osc ? ext_q + 3'h1 : ext_q;
      pin_q <= bus.timer1_ext_input;
    end
  end
  assign pin_tick = bus.timer1_ext_input && !pin_q;
  always_comb
  begin
    unique case (tmr_q[asp_pkg::TMR_SRC_LSB +: 3])
      asp_pkg::SRC_SYS: sys_en = 1'b1;
      asp_pkg::SRC_DIV4: sys_en = (pre_q[1:0] == 2'h3);
      asp_pkg::SRC_DIV12: sys_en = (pre_q == 6'h0b) || (pre_q == 6'h17)
        || (pre_q == 6'h23) || (pre_q == 6'h2f);
      asp_pkg::SRC_DIV48: sys_en = (pre_q == 6'h2f);
      asp_pkg::SRC_EXT8: sys_en = bus.ext_osc && (ext_q == 3'h7);
      asp_pkg::SRC_PIN: sys_en = pin_tick;
      default: sys_en = 1'b0;
    endcase
  end
  // tx timer and hidden rx copy, shared run and reload [R16] [R18]
  asp_baud u_tx_timer (
    .clk(CLOCK), .rst(RST), .run(tmr_q[asp_pkg::TMR_RUN]),
    .tick_en(sys_en), .reload(tmr_q[7:0]), .force_load(1'b0),
    .bit_tick(tx_tick)
  );
  asp_baud u_rx_timer (
    .clk(CLOCK), .rst(RST), .run(tmr_q[asp_pkg::TMR_RUN]),
    .tick_en(sys_en), .reload(tmr_q[7:0]), .force_load(rx_start),
    .bit_tick(rx_tick)
  );
  // start edge forces rx timer reload [R19]
  assign rx_start = ctl_q[asp_pkg::CTL_REN] && !rx_busy_q && rx_prev_q
    && !bus.serial_in_pin; // [R7]
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      rx_prev_q <= 1'b1;
    else
      rx_prev_q <= bus.serial_in_pin;
  end
  // transmitter: write starts frame [R5]
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      tx_sh_q <= 10'h3ff;
      tx_cnt_q <= 4'h0;
      tx_out_q <= 1'b1;
    end
    else if (bus.wr && bus.addr == asp_pkg::DEV_BUF)
    begin
      // start, lsb first data, ninth bit in 9-bit mode [R1] [R2] [R4]
      tx_sh_q <= {(ctl_q[asp_pkg::CTL_MODE] ? ctl_q[asp_pkg::CTL_TB8]
        : 1'b1), bus.wdata[7:0], 1'b0};
      tx_cnt_q <= ctl_q[asp_pkg::CTL_MODE] ? 4'(asp_pkg::BITS_9)
        : 4'(asp_pkg::BITS_8); // [R3]
    end
    else if (tx_tick && tx_cnt_q != 4'h0)
    begin
      tx_out_q <= tx_sh_q[0];
      tx_sh_q <= {1'b1, tx_sh_q[9:1]};
      tx_cnt_q <= tx_cnt_q - 4'h1;
    end
  end
  // done when the stop bit goes out [R6]
  assign tx_set = tx_tick && tx_cnt_q == 4'h1;
  // receiver: sample at bit midpoint via half-period tick
  assign rx_last = ctl_q[asp_pkg::CTL_MODE] ? 4'(asp_pkg::BITS_9)
    : 4'(asp_pkg::BITS_8);
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 9'h000;
    end
    else if (rx_start)
    begin
      rx_busy_q <= 1'b1;
      rx_cnt_q <= 4'h0;
    end
    else if (rx_busy_q && rx_tick)
    begin
      if (rx_cnt_q == 4'h0 && bus.serial_in_pin)
        rx_busy_q <= 1'b0;
      else if (rx_cnt_q == rx_last - 4'h1)
        rx_busy_q <= 1'b0;
      rx_cnt_q <= rx_cnt_q + 4'h1;
      if (rx_cnt_q != 4'h0)
        rx_sh_q <= {bus.serial_in_pin, rx_sh_q[8:1]};
    end
  end
  // end of frame acceptance [R8] [R9] [R11]
  assign rx_set = rx_busy_q && rx_tick && rx_cnt_q == rx_last - 4'h1;
  always_comb
  begin
    if (ctl_q[asp_pkg::CTL_MODE])
      accept = !ctl_q[asp_pkg::CTL_RI] &&
        (!ctl_q[asp_pkg::CTL_MCE] || rx_sh_q[8]);
    else
      accept = !ctl_q[asp_pkg::CTL_RI] &&
        (!ctl_q[asp_pkg::CTL_MCE] || bus.serial_in_pin);
  end
  // separate latch frees shifter [R12] [R10]
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      rx_latch_q <= 8'h00;
    else if (rx_set && accept)
      rx_latch_q <= ctl_q[asp_pkg::CTL_MODE] ? rx_sh_q[7:0]
        : rx_sh_q[8:1];
  end
  // control register; hardware set beats software clear [R15]
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      ctl_q <= asp_pkg::CTL_RESET;
    else
    begin
      if (bus.wr && bus.addr == asp_pkg::DEV_CTL)
        ctl_q <= bus.wdata[7:0] | (8'h01 << asp_pkg::CTL_ONE);
      if (tx_set)
        ctl_q[asp_pkg::CTL_TI] <= 1'b1;
      if (rx_set && accept)
      begin
        ctl_q[asp_pkg::CTL_RI] <= 1'b1;
        ctl_q[asp_pkg::CTL_RB8] <= ctl_q[asp_pkg::CTL_MODE] ? rx_sh_q[8]
          : bus.serial_in_pin;
      end
    end
  end
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      tmr_q <= asp_pkg::TMR_RESET;
    else if (bus.wr && bus.addr == asp_pkg::DEV_TMR)
      tmr_q <= bus.wdata;
  end
  // interrupt while either flag set [R14]
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      irq_q <= 1'b0;
    else
      irq_q <= ctl_q[asp_pkg::CTL_TI] || ctl_q[asp_pkg::CTL_RI];
  end
  // buffer reads return latch only [R13]
  always_comb
  begin
    unique case (bus.addr)
      asp_pkg::DEV_CTL: bus.rdata = {4'h0, ctl_q};
      asp_pkg::DEV_BUF: bus.rdata = {4'h0, rx_latch_q};
      asp_pkg::DEV_TMR: bus.rdata = tmr_q;
      default: bus.rdata = 12'h000;
    endcase
  end
  assign bus.irq = irq_q;
  assign bus.serial_out_pin = tx_out_q;
endmodule : asp_dev

/* tb/asp_asserts.sv */
/*
  asp_asserts: checks on the device register port and serial line.
  assumes: instantiated beside the interface; one clock, sync reset.
*/
`timescale 1ns/10ps
module asp_asserts (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic wr,
  input wire logic [1:0] addr,
  input wire logic [11:0] wdata,
  input wire logic [11:0] rdata,
  input wire logic irq,
  input wire logic serial_out_pin
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  // control word seen on two cycles with no write between
  sequence ctl_view;
    addr == asp_pkg::DEV_CTL && $past(addr) == asp_pkg::DEV_CTL && !$past(wr);
  endsequence
  sequence ti_rise;
    ctl_view ##0 (rdata[asp_pkg::CTL_TI] && !$past(rdata[asp_pkg::CTL_TI]));
  endsequence
  sequence ri_rise;
    ctl_view ##0 (rdata[asp_pkg::CTL_RI] && !$past(rdata[asp_pkg::CTL_RI]));
  endsequence
  idle_line_a: assert property ($fell(RST) |-> serial_out_pin [*2])
    else $error("line not idle after reset");
  tx_start_a: assert property (
    wr && addr == asp_pkg::DEV_BUF |-> ##[1:1000] !serial_out_pin)
    else $error("buffer write sent no start bit");
  tx_done_a: assert property (ti_rise |-> ##[0:1] serial_out_pin [*2])
    else $error("tx done outside stop bit");
  rx_enable_a: assert property (ri_rise |-> rdata[asp_pkg::CTL_REN])
    else $error("receive while disabled");
  addr_filter_a: assert property (
    ri_rise ##0 rdata[asp_pkg::CTL_MCE] |-> rdata[asp_pkg::CTL_RB8])
    else $error("filtered character accepted");
  irq_follow_a: assert property (
    $past(addr) == asp_pkg::DEV_CTL |->
    irq == ($past(rdata[1]) | $past(rdata[0])))
    else $error("irq does not follow flags");
  flag_hold_a: assert property (
    ctl_view |-> (~rdata[1:0] & $past(rdata[1:0])) == 2'h0)
    else $error("done flag cleared by hardware");
  ctl_keep_a: assert property (
    wr && addr == asp_pkg::DEV_CTL |=> addr != asp_pkg::DEV_CTL ||
    rdata[7:3] == {$past(wdata[7]), 1'b1, $past(wdata[5:3])})
    else $error("control bits not kept");
endmodule : asp_asserts

/* tb/async_serial_port_with_timer_baud_tb.sv */
/*
  bench: AXI4-Lite tasks drive the controller; serial line looped back.
  assumes: device and controller meet in asp_if; 100 MHz clock.
*/
`timescale 1ns/10ps
module async_serial_port_with_timer_baud_tb;
  logic CLOCK = 0;
  logic RST = 1;
  logic [7:0] AWADDR = 0;
  logic [7:0] ARADDR = 0;
  logic [31:0] WDATA = 0;
  logic AWVALID = 0;
  logic WVALID = 0;
  logic BREADY = 0;
  logic ARVALID = 0;
  logic RREADY = 0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
  logic [1:0] BRESP, RRESP, resp;
  logic [31:0] RDATA, got;
  logic [10:0] fr;
  int miscompares = 0;
  int checked = 0;
  int bt = 2 * (asp_pkg::TIMER_SPAN - 32'hf8);
  asp_if i_asp_if();
  asp_dev i_asp_dev(.CLOCK(CLOCK), .RST(RST), .bus(i_asp_if));
  asp_ctl i_asp_ctl(.CLOCK(CLOCK), .RST(RST), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .IRQ(IRQ), .dev(i_asp_if));
  asp_asserts i_asp_asserts(.CLOCK(CLOCK), .RST(RST), .wr(i_asp_if.wr),
    .addr(i_asp_if.addr), .wdata(i_asp_if.wdata), .rdata(i_asp_if.rdata),
    .irq(i_asp_if.irq), .serial_out_pin(i_asp_if.serial_out_pin));
  assign i_asp_if.serial_in_pin = i_asp_if.serial_out_pin;
  initial forever #5 CLOCK = ~CLOCK;
  // external timer clocks for the source selection test
  initial
  begin
    i_asp_if.ext_osc = 0;
    i_asp_if.timer1_ext_input = 0;
    forever
    begin
      @(posedge CLOCK);
      i_asp_if.ext_osc <= ~i_asp_if.ext_osc;
      i_asp_if.timer1_ext_input <= ~i_asp_if.timer1_ext_input;
    end
  end
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 0;
    w = 0;
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1;
    WVALID <= 1;
    BREADY <= 1;
    while (!(aw && w))
    begin
      @(posedge CLOCK);
      aw = aw | AWREADY;
      w = w | WREADY;
      if (aw)
        AWVALID <= 0;
      if (w)
        WVALID <= 0;
    end
    do @(posedge CLOCK); while (BVALID !== 1'b1);
    resp = BRESP;
    BREADY <= 0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1;
    RREADY <= 1;
    do @(posedge CLOCK); while (ARREADY !== 1'b1);
    ARVALID <= 0;
    do @(posedge CLOCK); while (RVALID !== 1'b1);
    got = RDATA;
    resp = RRESP;
    RREADY <= 0;
  endtask : axi_rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    axi_rd(a);
    chk(got & m, e);
  endtask : rdc
  // samples the line mid-bit from the start edge
  task automatic cap(input int n);
    @(negedge i_asp_if.serial_out_pin);
    fr = '0;
    repeat (bt / 2) @(posedge CLOCK);
    for (int i = 0; i < n; i++)
    begin
      fr[i] = i_asp_if.serial_out_pin;
      repeat (bt) @(posedge CLOCK);
    end
  endtask : cap
  task automatic send(input logic [7:0] d, input int n, input logic [10:0] e);
    fork
      axi_wr(asp_pkg::AX_BUF, {24'h0, d});
      cap(n);
    join
    chk(32'(fr), 32'(e));
    repeat (3 * bt) @(posedge CLOCK);
  endtask : send
  initial
  begin
    repeat (5) @(posedge CLOCK);
    RST <= 0;
    rdc(asp_pkg::AX_CTL, 32'hff, 32'h40);
    chk(32'(resp), 32'h0);
    rdc(asp_pkg::AX_STAT, 32'h4, 32'h4);
    axi_wr(8'h10, 32'h1);
    chk(32'(resp), 32'h2);
    axi_rd(8'h10);
    chk(32'(resp), 32'h2);
    $display("test reset and map done");
    axi_wr(asp_pkg::AX_TMR, 32'h8f8);
    chk(32'(resp), 32'h0);
    axi_wr(asp_pkg::AX_CTL, 32'h10);
    send(8'ha5, 10, {1'b0, 1'b1, 8'ha5, 1'b0});
    rdc(asp_pkg::AX_CTL, 32'h7, 32'h7);
    chk(32'(IRQ), 32'h1);
    send(8'h3c, 10, {1'b0, 1'b1, 8'h3c, 1'b0});
    rdc(asp_pkg::AX_BUF, 32'hff, 32'ha5);
    $display("test 8-bit frames done");
    axi_wr(asp_pkg::AX_CTL, 32'h98);
    rdc(asp_pkg::AX_CTL, 32'h3, 32'h0);
    chk(32'(IRQ), 32'h0);
    send(8'h5a, 11, {1'b1, 1'b1, 8'h5a, 1'b0});
    rdc(asp_pkg::AX_CTL, 32'h7, 32'h7);
    rdc(asp_pkg::AX_BUF, 32'hff, 32'h5a);
    axi_wr(asp_pkg::AX_CTL, 32'hb0);
    send(8'h77, 11, {1'b1, 1'b0, 8'h77, 1'b0});
    rdc(asp_pkg::AX_CTL, 32'h3, 32'h2);
    rdc(asp_pkg::AX_BUF, 32'hff, 32'h5a);
    axi_wr(asp_pkg::AX_CTL, 32'hb8);
    send(8'h77, 11, {1'b1, 1'b1, 8'h77, 1'b0});
    rdc(asp_pkg::AX_BUF, 32'hff, 32'h77);
    axi_wr(asp_pkg::AX_CTL, 32'h20);
    send(8'h11, 10, {1'b0, 1'b1, 8'h11, 1'b0});
    rdc(asp_pkg::AX_CTL, 32'h3, 32'h2);
    rdc(asp_pkg::AX_BUF, 32'hff, 32'h77);
    $display("test 9-bit and filter done");
    for (int s = 1; s < 6; s++)
    begin
      axi_wr(asp_pkg::AX_TMR, 32'h8ff | (32'(s) << 8));
      axi_wr(asp_pkg::AX_CTL, 32'h10);
      axi_wr(asp_pkg::AX_BUF, 32'h80 + 32'(s));
      do axi_rd(asp_pkg::AX_CTL); while (got[0] !== 1'b1);
      rdc(asp_pkg::AX_BUF, 32'hff, 32'h80 + 32'(s));
    end
    $display("test timer sources done");
    report_and_stop();
  end
  initial
  begin
    repeat (60000) @(posedge CLOCK);
    miscompares++;
    $display("FAIL %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : async_serial_port_with_timer_baud_tb
